// ==== hdl/out_ctrl_pkg.sv ====
// Constants, register map and encodings of the output control unit
package out_ctrl_pkg;
	// ==================================================================
	// Bus and register map
	localparam int ADDR_W = 6;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_SETPT = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_HYST = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_TON = 6'h0c;
	localparam logic [ADDR_W-1:0] OFS_TOFF = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_LOLIM = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_HILIM = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_REMOTE = 6'h1c;
	localparam logic [ADDR_W-1:0] OFS_CMD = 6'h20;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h24;
	// ==================================================================
	// Field positions
	localparam int CTRL_FUNC_LSB = 0;
	localparam int CTRL_SEL_LSB = 4;
	localparam int CTRL_TYPE_BIT = 8;
	localparam int REM_DIG_BIT = 16;
	localparam int STAT_DIG_BIT = 16;
	localparam int STAT_HOLD_BIT = 17;
	localparam int STAT_TIMER_BIT = 18;
	// ==================================================================
	// Encodings
	localparam logic [2:0] FUNC_OFF = 3'h0;
	localparam logic [2:0] FUNC_REMOTE = 3'h1;
	localparam logic [2:0] FUNC_FOLLOW = 3'h2;
	localparam logic [2:0] FUNC_ONOFF = 3'h3;
	localparam logic [2:0] FUNC_TIMER = 3'h4;
	localparam logic [2:0] SEL_NONE = 3'h0;
	localparam logic [2:0] SEL_MIN = 3'h1;
	localparam logic [2:0] SEL_MAX = 3'h5;
	localparam logic [7:0] CMD_RESET_OUT = 8'h20;
	localparam int NUM_CH = 5;
	// ==================================================================
	// Value ranges, in tenths and seconds
	localparam logic signed [16:0] SETPT_MIN = -17'sd400;
	localparam logic signed [16:0] SETPT_MAX = 17'sd20470;
	localparam logic [7:0] HYST_MAX = 8'hc8;
	localparam logic [14:0] TON_MIN = 15'h0001;
	localparam logic [9:0] ANA_FULL = 10'h3e8;
	localparam logic [31:0] ANA_FULL_W = 32'h0000_03e8;
	// ==================================================================
	// Reset values
	localparam logic [2:0] FUNC_RST = 3'h0;
	localparam logic [14:0] TON_RST = 15'h0001;
	// ==================================================================
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int SEC_NS = 1000000000;
	localparam int HOLD_SEC = 10;
	localparam logic [3:0] HOLD_LAST = 4'(HOLD_SEC - 1);
	localparam int TICK_W = 27;
	typedef enum logic [1:0] {TM_IDLE, TM_ON, TM_OFF, TM_DONE} timer_state_type;
endpackage

// ==== hdl/out_ctrl.sv ====
// Output control unit: remote, follow-input, on/off hysteresis and timer functions
// Functional notes
// - Remote mode drives digital output or analog 0.0..100.0% as commanded
// - Remote command state saved to non-volatile store and restored at power-up
// - Follow mode: digital output mirrors associated input if it is digital
// - Follow mode: digital output held off when associated input is not digital
// - Follow mode: analog output scales input between lower and upper limits
// - Function value 3 selects on/off hysteresis control
// - On/off control signal is one of input channels 1 to 5
// - On/off set-point accepts -40.0 to 2047.0
// - Hysteresis width accepts 0.0 to 20.0
// - Control type 0 is cooling, 1 is heating
// - Cooling: on at set-point+hyst or above, off at set-point-hyst or below
// - Heating: off at set-point+hyst or above, on at set-point-hyst or below
// - Function value 4 selects timer mode
// - Timer selection 0 is ungated, 1 to 5 gates from that channel
// - Gated timer triggers below set-point for type 0, above for type 1
// - Timer trigger set-point accepts -40.0 to 2047.0
// - Gated timer with zero off time gives one on period per trigger
// - Gated timer with both times nonzero cycles while trigger holds
// - Gated timer output stays off while trigger condition is false
// - Ungated timer cycles on and off continuously if off time is nonzero, else gives one on period
// - On time programmable 1 to 32767 seconds
// - Off time programmable 0 to 32767 seconds
// - Reset command clears timers, forces output off 10 s, then resumes
//
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/100ps
module out_ctrl
	import out_ctrl_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = SEC_NS / CLK_PERIOD_NS
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [NUM_CH-1:0][15:0] sens_val_i,
	input wire logic [NUM_CH-1:0] sens_dig_i,
	input wire logic [NUM_CH-1:0] sens_is_dig_i,
	input wire logic [10:0] nvm_data_i,
	output logic nvm_wr_o,
	output logic [10:0] nvm_data_o,
	output logic dig_out_o,
	output logic [9:0] ana_out_o
);
	// ==================================================================
	// Configuration registers
	logic [2:0] func;
	logic [2:0] sel;
	logic ctype;
	logic signed [16:0] setpt;
	logic [7:0] hyst;
	logic [14:0] ton;
	logic [14:0] toff;
	logic signed [15:0] lolim;
	logic signed [15:0] hilim;
	logic rem_dig;
	logic [9:0] rem_ana;
	logic restore_pend;
	logic hold_act;
	logic [3:0] hold_sec;
	logic [TICK_W-1:0] tick_cnt;
	logic tick;
	logic hyst_q;
	timer_state_type tm_state;
	logic [14:0] sec_cnt;
	logic bus_req;
	logic wr_en;
	logic [31:0] wmask_data;
	logic cmd_reset;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic signed [16:0] clamp_sp(input logic [15:0] v);
		logic signed [16:0] s;
		s = 17'(signed'(v));
		if (s < SETPT_MIN) begin
			s = SETPT_MIN;
		end else if (s > SETPT_MAX) begin
			s = SETPT_MAX;
		end
		return s;
	endfunction

	// ==================================================================
	// Avalon-MM slave: one wait cycle, write and read data at the edge waitrequest is low
	assign bus_req = avs_read_i | avs_write_i;
	assign wr_en = avs_write_i & ~avs_waitrequest_o;
	assign wmask_data = merge(32'h0000_0000, avs_writedata_i, avs_byteenable_i);
	assign cmd_reset = wr_en && avs_address_i == OFS_CMD && avs_byteenable_i[0]
		&& avs_writedata_i[7:0] == CMD_RESET_OUT;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			avs_waitrequest_o <= 1'b1;
		end else begin
			avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (avs_read_i && avs_waitrequest_o) begin
			case (avs_address_i)
				OFS_CTRL: avs_readdata_o <= {23'h000000, ctype, 1'b0, sel, 1'b0, func};
				OFS_SETPT: avs_readdata_o <= 32'(setpt);
				OFS_HYST: avs_readdata_o <= {24'h000000, hyst};
				OFS_TON: avs_readdata_o <= {17'h00000, ton};
				OFS_TOFF: avs_readdata_o <= {17'h00000, toff};
				OFS_LOLIM: avs_readdata_o <= 32'(lolim);
				OFS_HILIM: avs_readdata_o <= 32'(hilim);
				OFS_REMOTE: avs_readdata_o <= {15'h0000, rem_dig, 6'h00, rem_ana};
				OFS_STATUS: avs_readdata_o <= {13'h0000, tm_state == TM_ON, hold_act,
					dig_out_o, 6'h00, ana_out_o};
				default: avs_readdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// ==================================================================
	// Configuration writes, set-point, hysteresis, on and off times clamped to their ranges
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			func <= FUNC_RST;
			sel <= SEL_NONE;
			ctype <= 1'b0;
			setpt <= 17'sd0;
			hyst <= 8'h00;
			ton <= TON_RST;
			toff <= 15'h0000;
			lolim <= 16'sd0;
			hilim <= 16'sd0;
		end else if (wr_en) begin
			case (avs_address_i)
				OFS_CTRL: begin
					if (avs_byteenable_i[0]) begin
						func <= avs_writedata_i[CTRL_FUNC_LSB +: 3];
						sel <= (avs_writedata_i[CTRL_SEL_LSB +: 3] > SEL_MAX) ? SEL_NONE
							: avs_writedata_i[CTRL_SEL_LSB +: 3];
					end
					if (avs_byteenable_i[1]) begin
						ctype <= avs_writedata_i[CTRL_TYPE_BIT];
					end
				end
				OFS_SETPT: setpt <= clamp_sp(16'(merge(32'(setpt), wmask_data,
					avs_byteenable_i)));
				OFS_HYST: if (avs_byteenable_i[0]) begin
					hyst <= (avs_writedata_i[7:0] > HYST_MAX) ? HYST_MAX
						: avs_writedata_i[7:0];
				end
				OFS_TON: begin
					ton <= (merge(32'(ton), wmask_data, avs_byteenable_i) >> 0) == 32'h0
						? TON_MIN
						: merge(32'(ton), wmask_data, avs_byteenable_i) >= 32'h8000
						? 15'h7fff : 15'(merge(32'(ton), wmask_data, avs_byteenable_i));
				end
				OFS_TOFF: begin
					toff <= merge(32'(toff), wmask_data, avs_byteenable_i) >= 32'h8000
						? 15'h7fff
						: 15'(merge(32'(toff), wmask_data, avs_byteenable_i));
				end
				OFS_LOLIM: lolim <= 16'(merge(32'(lolim), wmask_data, avs_byteenable_i));
				OFS_HILIM: hilim <= 16'(merge(32'(hilim), wmask_data, avs_byteenable_i));
				default: ;
			endcase
		end
	end

	// ==================================================================
	// Remote command state, mirrored to non-volatile store and restored after power-up
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rem_dig <= 1'b0;
			rem_ana <= 10'h000;
			restore_pend <= 1'b1;
			nvm_wr_o <= 1'b0;
			nvm_data_o <= 11'h000;
		end else begin
			nvm_wr_o <= 1'b0;
			if (restore_pend) begin
				// Store contents are only trusted once reset has been released
				restore_pend <= 1'b0;
				rem_dig <= nvm_data_i[10];
				rem_ana <= (nvm_data_i[9:0] > ANA_FULL) ? ANA_FULL : nvm_data_i[9:0];
			end else if (wr_en && avs_address_i == OFS_REMOTE) begin
				rem_dig <= avs_byteenable_i[2] ? avs_writedata_i[REM_DIG_BIT] : rem_dig;
				rem_ana <= (avs_writedata_i[9:0] > ANA_FULL) ? ANA_FULL
					: avs_writedata_i[9:0];
				nvm_wr_o <= 1'b1;
				nvm_data_o <= {avs_byteenable_i[2] ? avs_writedata_i[REM_DIG_BIT] : rem_dig,
					(avs_writedata_i[9:0] > ANA_FULL) ? ANA_FULL : avs_writedata_i[9:0]};
			end
		end
	end

	// ==================================================================
	// Seconds time base and reset-output hold
	assign tick = tick_cnt == TICK_W'(TICK_CYCLES - 1);

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || cmd_reset || tick) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			hold_act <= 1'b0;
			hold_sec <= 4'h0;
		end else if (cmd_reset) begin
			hold_act <= 1'b1;
			hold_sec <= 4'h0;
		end else if (hold_act && tick) begin
			hold_sec <= hold_sec + 1'b1;
			hold_act <= hold_sec != HOLD_LAST;
		end
	end

	// ==================================================================
	// Selected channel and comparisons
	logic sel_ok;
	logic [2:0] ch_idx;
	logic signed [16:0] meas;
	logic signed [16:0] thr_hi;
	logic signed [16:0] thr_lo;
	logic trig;
	logic gated;

	assign sel_ok = sel >= SEL_MIN && sel <= SEL_MAX;
	assign ch_idx = sel_ok ? sel - SEL_MIN : 3'h0;
	assign meas = 17'(signed'(sens_val_i[ch_idx]));
	assign thr_hi = setpt + 17'(hyst);
	assign thr_lo = setpt - 17'(hyst);
	assign trig = ctype ? (meas > setpt) : (meas < setpt);
	assign gated = sel != SEL_NONE;

	// ==================================================================
	// On/off hysteresis state
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || cmd_reset || hold_act) begin
			hyst_q <= 1'b0;
		end else if (func == FUNC_ONOFF && sel_ok) begin
			if (meas >= thr_hi) begin
				hyst_q <= ~ctype;
			end else if (meas <= thr_lo) begin
				hyst_q <= ctype;
			end
			// Strictly inside the band the previous state stands
		end else begin
			hyst_q <= 1'b0;
		end
	end

	// ==================================================================
	// Timer
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || cmd_reset || hold_act || func != FUNC_TIMER) begin
			tm_state <= TM_IDLE;
			sec_cnt <= 15'h0000;
		end else if (gated && (!sel_ok || !trig)) begin
			tm_state <= TM_IDLE;
			sec_cnt <= 15'h0000;
		end else begin
			case (tm_state)
				TM_IDLE: begin
					tm_state <= TM_ON;
					sec_cnt <= 15'h0000;
				end
				TM_ON: if (tick) begin
					if (sec_cnt + 1'b1 >= ton) begin
						sec_cnt <= 15'h0000;
						// Zero off time ends a trigger episode after one pulse
						tm_state <= (toff == 15'h0000) ? TM_DONE : TM_OFF;
					end else begin
						sec_cnt <= sec_cnt + 1'b1;
					end
				end
				TM_OFF: if (tick) begin
					if (sec_cnt + 1'b1 >= toff) begin
						sec_cnt <= 15'h0000;
						tm_state <= TM_ON;
					end else begin
						sec_cnt <= sec_cnt + 1'b1;
					end
				end
				TM_DONE: tm_state <= TM_DONE;
				default: tm_state <= TM_IDLE;
			endcase
		end
	end

	// ==================================================================
	// Follow-input analog scaling
	logic [31:0] span;
	logic [31:0] above;
	logic [9:0] scaled;

	always_comb begin
		span = 32'(signed'(hilim) - signed'(lolim));
		above = 32'(meas - 17'(lolim));
		if (meas <= 17'(lolim) || hilim <= lolim) begin
			scaled = 10'h000;
		end else if (meas >= 17'(hilim)) begin
			scaled = ANA_FULL;
		end else begin
			scaled = 10'((above * ANA_FULL_W) / span);
		end
	end

	// ==================================================================
	// Output selection, registered
	logic next_dig;
	logic [9:0] next_ana;

	always_comb begin
		next_dig = 1'b0;
		next_ana = 10'h000;
		if (!hold_act && !cmd_reset) begin
			case (func)
				FUNC_REMOTE: begin
					next_dig = rem_dig;
					next_ana = rem_ana;
				end
				FUNC_FOLLOW: begin
					next_dig = sel_ok && sens_is_dig_i[ch_idx] && sens_dig_i[ch_idx];
					next_ana = sel_ok ? scaled : 10'h000;
				end
				FUNC_ONOFF: next_dig = hyst_q;
				FUNC_TIMER: next_dig = tm_state == TM_ON;
				default: next_dig = 1'b0;
			endcase
			if (func == FUNC_ONOFF || func == FUNC_TIMER) begin
				next_ana = next_dig ? ANA_FULL : 10'h000;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			dig_out_o <= 1'b0;
			ana_out_o <= 10'h000;
		end else begin
			dig_out_o <= next_dig;
			ana_out_o <= next_ana;
		end
	end

	// ==================================================================
	// Checks
	chk_remote_follow: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		func == FUNC_REMOTE && !hold_act && !cmd_reset |=> dig_out_o == $past(rem_dig)
		&& ana_out_o == $past(rem_ana)) else $error("remote output mismatch");
	chk_nvm_save: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		wr_en && avs_address_i == OFS_REMOTE && !restore_pend |=> nvm_wr_o
		&& nvm_data_o[9:0] == rem_ana) else $error("remote state not saved");
	chk_follow_dig: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		func == FUNC_FOLLOW && sel_ok && !hold_act && !cmd_reset |=> dig_out_o ==
		$past(sens_is_dig_i[ch_idx] & sens_dig_i[ch_idx])) else $error("follow mismatch");
	chk_cool_on: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		func == FUNC_ONOFF && sel_ok && !ctype && !hold_act && !cmd_reset && meas >= thr_hi
		|=> hyst_q ##1 (dig_out_o || hold_act)) else $error("cooling did not turn on");
	chk_heat_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		func == FUNC_ONOFF && sel_ok && ctype && meas >= thr_hi |=> !hyst_q ##1 !dig_out_o)
		else $error("heating did not turn off");
	chk_band_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		func == FUNC_ONOFF && sel_ok && !hold_act && !cmd_reset && meas > thr_lo
		&& meas < thr_hi |=> hyst_q == $past(hyst_q)) else $error("state changed in band");
	chk_gate_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		func == FUNC_TIMER && gated && !trig ##1 func == FUNC_TIMER |=> !dig_out_o)
		else $error("gated timer on without trigger");
	chk_hold_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		cmd_reset |=> (!dig_out_o && ana_out_o == 10'h000 && hold_act)[*8])
		else $error("reset command did not force off");
	chk_cfg_range: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		hyst <= HYST_MAX && ton >= TON_MIN && setpt >= SETPT_MIN && setpt <= SETPT_MAX)
		else $error("configuration out of range");
	chk_single_shot: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		tm_state == TM_DONE && trig && func == FUNC_TIMER && !cmd_reset |=> tm_state == TM_DONE)
		else $error("single shot re-armed");
	cov_remote_wr: cover property (@(posedge clk_sys_i) wr_en && avs_address_i == OFS_REMOTE);
	cov_timer_on: cover property (@(posedge clk_sys_i) func == FUNC_TIMER && tm_state == TM_ON);
	cov_hold: cover property (@(posedge clk_sys_i) cmd_reset ##1 hold_act);
	cov_band: cover property (@(posedge clk_sys_i) func == FUNC_ONOFF && hyst_q && meas < thr_hi);
endmodule // out_ctrl

// ==== tb/far_side_model.sv ====
// Far-side model: five sensor channels and the non-volatile state store
`timescale 1ns/100ps
module far_side_model
	import out_ctrl_pkg::*;
#(
	parameter logic [10:0] NVM_INIT = 11'h5f4
) (
	input wire logic clk_sys_i,
	input wire logic nvm_wr_i,
	input wire logic [10:0] nvm_data_i,
	output logic [NUM_CH-1:0][15:0] sens_val_o,
	output logic [NUM_CH-1:0] sens_dig_o,
	output logic [NUM_CH-1:0] sens_is_dig_o,
	output logic [10:0] nvm_data_o
);
	// ==================================================================
	// Non-volatile store
	logic [10:0] store = NVM_INIT;
	assign nvm_data_o = store;
	// Not cleared by the block reset, so a saved state survives it like a power cycle
	always @(posedge clk_sys_i) begin
		if (nvm_wr_i === 1'b1) begin
			store <= nvm_data_i;
		end
	end
	// ==================================================================
	// Sensor channels
	initial begin
		sens_val_o = '0;
		sens_dig_o = '0;
		sens_is_dig_o = '0;
	end
	// Called just after a rising edge; channel numbers run 1 to 5
	task automatic set_ch(input int ch, input logic [15:0] v, input logic d, input logic isd);
		sens_val_o[ch-1] <= v;
		sens_dig_o[ch-1] <= d;
		sens_is_dig_o[ch-1] <= isd;
	endtask
endmodule // far_side_model

// ==== tb/tb_out_ctrl.sv ====
// Self-checking testbench of the output control unit
`timescale 1ns/100ps
module tb_out_ctrl;
	import out_ctrl_pkg::*;
	localparam int T = 20;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [ADDR_W-1:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [NUM_CH-1:0][15:0] sens_val;
	logic [NUM_CH-1:0] sens_dig;
	logic [NUM_CH-1:0] sens_is_dig;
	logic [10:0] nvm_rd;
	logic nvm_wr_o;
	logic [10:0] nvm_data_o;
	logic dig_out_o;
	logic [9:0] ana_out_o;
	int num_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	int n;
	logic [31:0] q;
	int vals [2][4] = '{'{60, 45, 20, 45}, '{20, 45, 60, 45}};
	logic exps [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
	// ==================================================================
	// Design and far side
	out_ctrl #(.TICK_CYCLES(T)) i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
		.avs_writedata_i(avs_writedata), .avs_byteenable_i(4'hf),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.sens_val_i(sens_val), .sens_dig_i(sens_dig), .sens_is_dig_i(sens_is_dig),
		.nvm_data_i(nvm_rd), .nvm_wr_o(nvm_wr_o), .nvm_data_o(nvm_data_o),
		.dig_out_o(dig_out_o), .ana_out_o(ana_out_o));
	far_side_model i_far (.clk_sys_i(clk_sys_i), .nvm_wr_i(nvm_wr_o),
		.nvm_data_i(nvm_data_o), .sens_val_o(sens_val), .sens_dig_o(sens_dig),
		.sens_is_dig_o(sens_is_dig), .nvm_data_o(nvm_rd));
	// ==================================================================
	// Clock and hang guard
	initial begin
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			final_report();
		end
	end
	// ==================================================================
	// Tasks
	task automatic final_report;
		if (num_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rng(input int v, input int lo, input int hi);
		total_checks++;
		if (v < lo || v > hi) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
		end
	endtask
	// Entered just after a rising edge; holds the request until waitrequest is sampled low
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clk_sys_i);
		end while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		// One idle edge, so a following call never reassigns a strobe in this time step
		@(posedge clk_sys_i);
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		cmp(q, exp);
	endtask
	task automatic out_chk(input logic dg, input logic [9:0] an);
		repeat (4) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		cmp({21'h0, dig_out_o, ana_out_o}, {21'h0, dg, an});
		@(posedge clk_sys_i);
	endtask
	// Counts falling edges with the output at lvl; entered on a falling edge
	task automatic run(input logic lvl, output int cnt);
		cnt = 0;
		while (dig_out_o === lvl && cnt < 3000) begin
			cnt++;
			@(negedge clk_sys_i);
		end
	endtask
	// ==================================================================
	// Main sequence
	initial begin
		repeat (4) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		out_chk(1'b0, 10'h000);
		rd_chk(OFS_CTRL, 32'h0000_0000);
		wr(OFS_CTRL, 32'h0000_0001);
		out_chk(1'b1, 10'h1f4);
		wr(OFS_REMOTE, 32'h0000_03e8);
		out_chk(1'b0, 10'h3e8);
		cmp({21'h0, i_far.store}, 32'h0000_03e8);
		wr(OFS_REMOTE, 32'h0001_0000);
		out_chk(1'b1, 10'h000);
		wr(OFS_CMD, {24'h0, CMD_RESET_OUT});
		@(negedge clk_sys_i);
		run(1'b1, n);
		run(1'b0, n);
		rng(n, 10 * T - 2, 10 * T + 2);
		@(posedge clk_sys_i);
		rd_chk(OFS_STATUS, 32'h0001_0000);
		// Unmapped place and read-only status
		rd_chk(6'h3c, 32'h0000_0000);
		wr(OFS_STATUS, 32'hffff_ffff);
		rd_chk(OFS_STATUS, 32'h0001_0000);
		// Reset in mid-run stands for a power cycle; the saved remote state must return
		rst_n_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		wr(OFS_CTRL, 32'h0000_0001);
		out_chk(1'b1, 10'h000);
		// Follow the input of channel 2
		i_far.set_ch(2, 16'h015e, 1'b1, 1'b1);
		wr(OFS_LOLIM, 32'h0000_0064);
		wr(OFS_HILIM, 32'h0000_0258);
		wr(OFS_CTRL, 32'h0000_0022);
		out_chk(1'b1, 10'h1f4);
		i_far.set_ch(2, 16'h0032, 1'b0, 1'b1);
		out_chk(1'b0, 10'h000);
		i_far.set_ch(2, 16'h02bc, 1'b1, 1'b0);
		out_chk(1'b0, 10'h3e8);
		// On/off: cooling on channel 1, heating on channel 5, band 2.0 to 6.0
		wr(OFS_SETPT, 32'h0000_0028);
		wr(OFS_HYST, 32'h0000_0014);
		for (int k = 0; k < 2; k++) begin
			i_far.set_ch(k * 4 + 1, 16'h0032, 1'b0, 1'b0);
			wr(OFS_CTRL, 32'(k * 256 + (k * 4 + 1) * 16 + 3));
			out_chk(1'b0, 10'h000);
			for (int i = 0; i < 4; i++) begin
				i_far.set_ch(k * 4 + 1, 16'(vals[k][i]), 1'b0, 1'b0);
				out_chk(exps[i], exps[i] ? ANA_FULL : 10'h000);
			end
		end
		// Free-running cyclic timer, on 2 s, off 1 s
		wr(OFS_TON, 32'h0000_0002);
		wr(OFS_TOFF, 32'h0000_0001);
		wr(OFS_CTRL, 32'h0000_0004);
		@(negedge clk_sys_i);
		run(1'b0, n);
		run(1'b1, n);
		run(1'b0, n);
		rng(n, T - 1, T + 1);
		run(1'b1, n);
		rng(n, 2 * T - 1, 2 * T + 1);
		@(posedge clk_sys_i);
		// Single-shot timer gated by channel 3 below 10.0
		i_far.set_ch(3, 16'h00c8, 1'b0, 1'b0);
		wr(OFS_SETPT, 32'h0000_0064);
		wr(OFS_TOFF, 32'h0000_0000);
		wr(OFS_TON, 32'h0000_0001);
		wr(OFS_CTRL, 32'h0000_0034);
		out_chk(1'b0, 10'h000);
		for (int r = 0; r < 2; r++) begin
			i_far.set_ch(3, 16'h0032, 1'b0, 1'b0);
			@(negedge clk_sys_i);
			run(1'b0, n);
			run(1'b1, n);
			rng(n, 1, T + 1);
			run(1'b0, n);
			rng(n, 3000, 3000);
			@(posedge clk_sys_i);
			i_far.set_ch(3, 16'h00c8, 1'b0, 1'b0);
			out_chk(1'b0, 10'h000);
		end
		// Cyclic timer gated by channel 3 above 10.0, on 1 s, off 2 s
		wr(OFS_TOFF, 32'h0000_0002);
		i_far.set_ch(3, 16'h0032, 1'b0, 1'b0);
		wr(OFS_CTRL, 32'h0000_0134);
		out_chk(1'b0, 10'h000);
		i_far.set_ch(3, 16'h00c8, 1'b0, 1'b0);
		@(negedge clk_sys_i);
		run(1'b0, n);
		run(1'b1, n);
		run(1'b0, n);
		rng(n, 2 * T - 1, 2 * T + 1);
		run(1'b1, n);
		rng(n, T - 1, T + 1);
		@(posedge clk_sys_i);
		i_far.set_ch(3, 16'h0032, 1'b0, 1'b0);
		out_chk(1'b0, 10'h000);
		final_report();
	end
endmodule // tb_out_ctrl
